// ### rap_pkg.sv
// Constants and types for the two-wire register access port.
// Assumes one byte-wide register map behind a serial slave.
package rap_pkg;
  // ---------------------------------------------------------
  // Bus addressing
  // ---------------------------------------------------------
  localparam logic [6:0] DEV_ADDR  = 7'h60;  // Own slave address
  localparam logic [3:0] CNT_FULL  = 4'h8;   // Bits in a byte
  localparam logic [3:0] CNT_LAST  = 4'h7;   // Last sent bit
  // ---------------------------------------------------------
  // Bus rates in kHz and link oversampling
  // ---------------------------------------------------------
  localparam int STD_SCL_KHZ   = 100;
  localparam int FAST_SCL_KHZ  = 400;
  localparam int FASTP_SCL_KHZ = 1000;
  localparam int HS_SCL_KHZ    = 3400;
  localparam int SAMPLES_PER_BIT = 8;  // Link samples per bit
  // ---------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------
  localparam logic [7:0] OFS_DEVICE_REVISION_ID      = 8'h00;
  localparam logic [7:0] OFS_OTP_VERSION_ID          = 8'h01;
  localparam logic [7:0] OFS_CONV0_CONTROL_A         = 8'h02;
  localparam logic [7:0] OFS_CONV0_CONTROL_B         = 8'h03;
  localparam logic [7:0] OFS_CONV1_CONTROL_A         = 8'h04;
  localparam logic [7:0] OFS_CONV1_CONTROL_B         = 8'h05;
  localparam logic [7:0] OFS_CONV0_VOLTAGE_SET       = 8'h06;
  localparam logic [7:0] OFS_CONV1_VOLTAGE_SET       = 8'h07;
  localparam logic [7:0] OFS_LIN0_CONTROL            = 8'h08;
  localparam logic [7:0] OFS_LIN1_CONTROL            = 8'h09;
  localparam logic [7:0] OFS_LIN0_VOLTAGE_SET        = 8'h0A;
  localparam logic [7:0] OFS_LIN1_VOLTAGE_SET        = 8'h0B;
  localparam logic [7:0] OFS_CONV0_SEQUENCE_DELAYS   = 8'h0C;
  localparam logic [7:0] OFS_CONV1_SEQUENCE_DELAYS   = 8'h0D;
  localparam logic [7:0] OFS_LIN0_SEQUENCE_DELAYS    = 8'h0E;
  localparam logic [7:0] OFS_LIN1_SEQUENCE_DELAYS    = 8'h0F;
  localparam logic [7:0] OFS_OUTPUT1_SEQUENCE_DELAYS = 8'h10;
  localparam logic [7:0] OFS_OUTPUT2_SEQUENCE_DELAYS = 8'h11;
  localparam logic [7:0] OFS_GENERAL_OUTPUT_CONTROL  = 8'h12;
  localparam logic [7:0] OFS_DEVICE_SETTINGS         = 8'h13;
  // Writable window runs from the first control register
  localparam int NUM_RW  = 18;
  localparam int RW_BITS = NUM_RW * 8;
  // Reserved low field of the revision register
  localparam logic [5:0] REV_LOW_RST = 6'h02;
  // ---------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_RX_ADDR, PH_RX_REG, PH_RX_DATA,
    PH_ACK, PH_TX, PH_TX_ACK, PH_SKIP
  } rap_phase_type;
  typedef enum logic [1:0] {
    MODE_SHUTDOWN, MODE_LOAD, MODE_STANDBY
  } rap_mode_type;
endpackage

// ### rap_word_sync.sv
// Toggle-based word crossing between two clock domains.
// Assumes the source spaces its events by four or more
// destination cycles and holds nothing else on the word.
`timescale 1ns/1ns
`default_nettype none
module rap_word_sync #(
  parameter int WIDTH = 8
) (
  // Source domain
  input  wire logic             srcClk,
  input  wire logic             srcRstN,
  input  wire logic             srcValid,
  input  wire logic [WIDTH-1:0] srcData,
  // Destination domain
  input  wire logic             dstClk,
  input  wire logic             dstRstN,
  output logic                  dstValid,
  output logic [WIDTH-1:0]      dstData
);
  // ---------------------------------------------------------
  // State
  // ---------------------------------------------------------
  typedef struct packed {
    logic             tog;   // Flips once per event
    logic [WIDTH-1:0] hold;  // Word held for the far side
  } rap_src_type;
  typedef struct packed {
    logic             s1;    // First stage, read by s2 only
    logic             s2;
    logic             s3;    // Edge reference
    logic             valid;
    logic [WIDTH-1:0] data;
  } rap_dst_type;
  rap_src_type sq, sd;
  rap_dst_type dq, dd;

  if (WIDTH < 1) begin : g_chk
    $error("rap_word_sync: WIDTH must be positive");
  end

  // Source: capture word, flip toggle
  always_comb begin
    sd = sq;
    if (srcValid) begin
      sd.tog  = ~sq.tog;
      sd.hold = srcData;
    end
  end
  always_ff @(posedge srcClk or negedge srcRstN) begin
    if (!srcRstN) sq <= '0;
    else sq <= sd;
  end

  // Destination: sync toggle; word is stable by then
  always_comb begin
    dd       = dq;
    dd.s1    = sq.tog;
    dd.s2    = dq.s1;
    dd.s3    = dq.s2;
    dd.valid = dq.s2 ^ dq.s3;
    if (dq.s2 ^ dq.s3) dd.data = sq.hold;
  end
  always_ff @(posedge dstClk or negedge dstRstN) begin
    if (!dstRstN) dq <= '0;
    else dq <= dd;
  end

  assign dstValid = dq.valid;
  assign dstData  = dq.data;
endmodule // rap_word_sync
`default_nettype wire

// ### rap_register_port.sv
// Two-wire serial slave with its byte-wide register map.
// Assumes open-drain pins resolved outside, a link clock
// far above the bus rate, and one async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module rap_register_port #(
  parameter int          LINK_CLK_KHZ     = 31250,
  parameter logic [1:0]  PART_ID_CODE     = 2'h1,   // Arbitrary
  parameter logic [7:0]  OTP_VERSION_CODE = 8'h5A,  // Arbitrary
  parameter logic [rap_pkg::RW_BITS-1:0] OTP_MASK = '1,
  parameter logic [rap_pkg::RW_BITS-1:0] RW_RESET = '0
) (
  // System clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  // Link clock
  input  wire logic                        linkClk,
  // Serial pins
  input  wire logic                        sclIn,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOe,
  // Supply and defaults
  input  wire logic                        supplyLockout,
  input  wire logic [rap_pkg::RW_BITS-1:0] otpDefaults,
  // Register contents and mode
  output logic [rap_pkg::RW_BITS-1:0]      ctrlRegs,
  output logic [1:0]                       devMode
);
  import rap_pkg::*;

  // ---------------------------------------------------------
  // Rate check
  // ---------------------------------------------------------
  // The link samples both pins; too slow a clock misses edges
  if (LINK_CLK_KHZ < SAMPLES_PER_BIT * HS_SCL_KHZ) begin : g_chk
    $error("rap_register_port: link clock too slow");
  end

  // ---------------------------------------------------------
  // Link domain state
  // ---------------------------------------------------------
  typedef struct packed {
    logic          sclS1;   // Pin syncs, first stages
    logic          sclS2;
    logic          sclS3;   // Previous clock level
    logic          sdaS1;
    logic          sdaS2;
    logic          sdaS3;   // Previous data level
    logic          lockS1;
    logic          lockS2;
    rap_phase_type ph;      // Transfer phase
    rap_phase_type after;   // Phase after the ack slot
    logic [3:0]    cnt;     // Bit counter
    logic [7:0]    shift;   // Byte shifter
    logic [7:0]    idx;     // Register index
    logic [7:0]    txByte;  // Value for read bytes
    logic          sdaOut;
    logic          sdaOe;
    logic          wrValid; // Write event pulse
    logic [15:0]   wrWord;  // Index and data
    logic          rdReq;   // Read request pulse
  } rap_link_type;
  rap_link_type lq, ld;

  // ---------------------------------------------------------
  // System domain state
  // ---------------------------------------------------------
  typedef struct packed {
    logic                       lockS1;
    logic                       lockS2;
    rap_mode_type               mode;
    logic [NUM_RW-1:0][7:0]     rw;      // Writable registers
    logic                       rdValid;
    logic [7:0]                 rdData;
  } rap_sys_type;
  rap_sys_type sq, sd;

  // Crossing wires
  logic        wrValidS;   // Write arrives in system domain
  logic [15:0] wrWordS;
  logic        rdReqS;     // Read index arrives
  logic [7:0]  rdIdxS;
  logic        rdValidL;   // Read value arrives at link
  logic [7:0]  rdDataL;

  // ---------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------
  // Writes go down to the register file
  rap_word_sync #(.WIDTH(16)) u_wr (
    .srcClk   (linkClk),
    .srcRstN  (arst_n),
    .srcValid (lq.wrValid),
    .srcData  (lq.wrWord),
    .dstClk   (ref_clk),
    .dstRstN  (arst_n),
    .dstValid (wrValidS),
    .dstData  (wrWordS)
  );
  // Read index goes down
  rap_word_sync #(.WIDTH(8)) u_rdq (
    .srcClk   (linkClk),
    .srcRstN  (arst_n),
    .srcValid (lq.rdReq),
    .srcData  (lq.idx),
    .dstClk   (ref_clk),
    .dstRstN  (arst_n),
    .dstValid (rdReqS),
    .dstData  (rdIdxS)
  );
  // Read value comes back up
  rap_word_sync #(.WIDTH(8)) u_rdd (
    .srcClk   (ref_clk),
    .srcRstN  (arst_n),
    .srcValid (sq.rdValid),
    .srcData  (sq.rdData),
    .dstClk   (linkClk),
    .dstRstN  (arst_n),
    .dstValid (rdValidL),
    .dstData  (rdDataL)
  );

  // ---------------------------------------------------------
  // Link pin events
  // ---------------------------------------------------------
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic byteDone;
  logic [7:0] idxPlus;
  always_comb begin
    sclRise  = lq.sclS2 & ~lq.sclS3;
    sclFall  = ~lq.sclS2 & lq.sclS3;
    // Data edge with clock high both samples
    startEv  = lq.sclS2 & lq.sclS3 & ~lq.sdaS2 & lq.sdaS3;
    stopEv   = lq.sclS2 & lq.sclS3 & lq.sdaS2 & ~lq.sdaS3;
    byteDone = sclFall && (lq.cnt == CNT_FULL);
    idxPlus  = lq.idx + 8'h01;
  end

  // ---------------------------------------------------------
  // Link transfer engine
  // ---------------------------------------------------------
  always_comb begin
    ld         = lq;
    ld.wrValid = 1'b0;
    ld.rdReq   = 1'b0;
    // Two flops before any logic reads a pin
    ld.sclS1  = sclIn;
    ld.sclS2  = lq.sclS1;
    ld.sclS3  = lq.sclS2;
    ld.sdaS1  = sdaIn;
    ld.sdaS2  = lq.sdaS1;
    ld.sdaS3  = lq.sdaS2;
    ld.lockS1 = supplyLockout;
    ld.lockS2 = lq.lockS1;
    // Latest register value for reads
    if (rdValidL) ld.txByte = rdDataL;
    if (lq.lockS2) begin
      // Supply low: let go of the line, forget the transfer
      ld.ph    = PH_IDLE;
      ld.sdaOe = 1'b0;
    end else if (startEv) begin
      // Also a repeated start, from any phase
      ld.ph    = PH_RX_ADDR;
      ld.cnt   = 4'h0;
      ld.sdaOe = 1'b0;
    end else if (stopEv) begin
      ld.ph    = PH_IDLE;
      ld.sdaOe = 1'b0;
    end else begin
      unique case (lq.ph)
        // Waiting for a start
        PH_IDLE, PH_SKIP: begin
          ld.sdaOe = 1'b0;
        end
        // Receiving a byte, sampled on rising clock
        PH_RX_ADDR, PH_RX_REG, PH_RX_DATA: begin
          if (sclRise && lq.cnt < CNT_FULL) begin
            ld.shift = {lq.shift[6:0], lq.sdaS2};
            ld.cnt   = lq.cnt + 4'h1;
          end else if (byteDone) begin
            // Ninth pulse: acknowledge
            ld.cnt    = 4'h0;
            ld.ph     = PH_ACK;
            ld.sdaOe  = 1'b1;
            ld.sdaOut = 1'b0;
            if (lq.ph == PH_RX_ADDR) begin
              if (lq.shift[7:1] == DEV_ADDR) begin
                // Low direction bit writes
                if (lq.shift[0]) begin
                  ld.after = PH_TX;
                  ld.rdReq = 1'b1;
                end else begin
                  ld.after = PH_RX_REG;
                end
              end else begin
                // Not ours: silent until next start
                ld.ph    = PH_SKIP;
                ld.sdaOe = 1'b0;
              end
            end else if (lq.ph == PH_RX_REG) begin
              ld.idx   = lq.shift;
              ld.after = PH_RX_DATA;
            end else begin
              // Data byte: store, then step the index
              ld.wrValid = 1'b1;
              ld.wrWord  = {lq.idx, lq.shift};
              ld.idx     = idxPlus;
              ld.after   = PH_RX_DATA;
            end
          end
        end
        // Ack slot ends on the falling clock
        PH_ACK: begin
          if (sclFall) begin
            ld.ph  = lq.after;
            ld.cnt = 4'h0;
            if (lq.after == PH_TX) begin
              // Most significant bit goes out first
              ld.shift  = ld.txByte;
              ld.sdaOut = ld.txByte[7];
              ld.sdaOe  = 1'b1;
            end else begin
              ld.sdaOe  = 1'b0;
            end
          end
        end
        // Sending a byte, changing data on falling clock
        PH_TX: begin
          if (sclFall) begin
            if (lq.cnt == CNT_LAST) begin
              // Release for the master's ack
              ld.sdaOe = 1'b0;
              ld.ph    = PH_TX_ACK;
            end else begin
              ld.shift  = {lq.shift[6:0], 1'b0};
              ld.sdaOut = lq.shift[6];
              ld.cnt    = lq.cnt + 4'h1;
            end
          end
        end
        // Master answers; index stays put
        PH_TX_ACK: begin
          if (sclRise) begin
            if (lq.sdaS2) begin
              ld.ph = PH_SKIP;
            end else begin
              ld.ph    = PH_ACK;
              ld.after = PH_TX;
            end
          end
        end
      endcase
    end
  end

  // Link registers
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      // Pin syncs start at the idle level: no false edge after reset
      lq       <= '0;
      lq.sclS1 <= 1'b1;
      lq.sclS2 <= 1'b1;
      lq.sclS3 <= 1'b1;
      lq.sdaS1 <= 1'b1;
      lq.sdaS2 <= 1'b1;
      lq.sdaS3 <= 1'b1;
    end else begin
      lq <= ld;
    end
  end

  assign sdaOut = lq.sdaOut;
  assign sdaOe  = lq.sdaOe;

  // ---------------------------------------------------------
  // Register read decode
  // ---------------------------------------------------------
  // Unmapped offsets read as zero
  function automatic logic [7:0] regRead(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == OFS_DEVICE_REVISION_ID)
      v = {PART_ID_CODE, REV_LOW_RST};
    else if (a == OFS_OTP_VERSION_ID)
      v = OTP_VERSION_CODE;
    else if (a <= OFS_DEVICE_SETTINGS)
      v = sq.rw[5'(a - OFS_CONV0_CONTROL_A)];
    return v;
  endfunction

  // ---------------------------------------------------------
  // Mode and register file
  // ---------------------------------------------------------
  logic [7:0] wrAddrS;
  logic [7:0] wrDataS;
  logic       wrHitS;
  always_comb begin
    wrAddrS = wrWordS[15:8];
    wrDataS = wrWordS[7:0];
    wrHitS  = wrValidS && (sq.mode == MODE_STANDBY)
           && (wrAddrS >= OFS_CONV0_CONTROL_A)
           && (wrAddrS <= OFS_DEVICE_SETTINGS);
  end

  always_comb begin
    sd         = sq;
    sd.rdValid = 1'b0;
    sd.lockS1  = supplyLockout;
    sd.lockS2  = sq.lockS1;
    unique case (sq.mode)
      // Supply below lockout level
      MODE_SHUTDOWN: begin
        if (!sq.lockS2) sd.mode = MODE_LOAD;
      end
      // Copy marked default bits, one cycle
      MODE_LOAD: begin
        sd.rw   = (sq.rw & ~OTP_MASK) | (otpDefaults & OTP_MASK);
        sd.mode = MODE_STANDBY;
      end
      // Host may read and write
      MODE_STANDBY: begin
        if (wrHitS) sd.rw[5'(wrAddrS - OFS_CONV0_CONTROL_A)] = wrDataS;
      end
      // Unused code: fall back to shutdown
      default: sd.mode = MODE_SHUTDOWN;
    endcase
    // Reads answer in every mode so the link never hangs
    if (rdReqS) begin
      sd.rdValid = 1'b1;
      sd.rdData  = regRead(rdIdxS);
    end
    // Lockout wipes the map back to reset contents
    if (sq.lockS2) begin
      sd.mode = MODE_SHUTDOWN;
      sd.rw   = RW_RESET;
    end
  end

  // System registers; map starts from its reset contents
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sq.lockS1  <= 1'b1;
      sq.lockS2  <= 1'b1;
      sq.mode    <= MODE_SHUTDOWN;
      sq.rw      <= RW_RESET;
      sq.rdValid <= 1'b0;
      sq.rdData  <= 8'h00;
    end else begin
      sq <= sd;
    end
  end

  assign ctrlRegs = sq.rw;
  assign devMode  = sq.mode;

  // ---------------------------------------------------------
  // Checks, link domain
  // ---------------------------------------------------------
  sequence s_rx_byte_end;
    (lq.ph == PH_RX_REG || lq.ph == PH_RX_DATA) && byteDone && !lq.lockS2;
  endsequence
  sequence s_addr_end;
    lq.ph == PH_RX_ADDR && byteDone && !lq.lockS2;
  endsequence

  a_lockout_quiet: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    lq.lockS2 |=> !lq.sdaOe ##1 !lq.sdaOe)
    else $error("data line driven during lockout");

  a_ack_ninth_low: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    s_rx_byte_end |=> lq.ph == PH_ACK && lq.sdaOe && !lq.sdaOut)
    else $error("byte not acknowledged");

  a_foreign_addr: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    s_addr_end and lq.shift[7:1] != DEV_ADDR |=> lq.ph == PH_SKIP && !lq.sdaOe)
    else $error("foreign address answered");

  a_skip_released: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    lq.ph == PH_SKIP |-> !lq.sdaOe)
    else $error("line driven while ignoring");

  a_read_dir: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    s_addr_end and lq.shift == {DEV_ADDR, 1'b1} |=> lq.after == PH_TX && lq.rdReq)
    else $error("read direction not taken");

  a_start_detect: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    startEv && !lq.lockS2 |=> lq.ph == PH_RX_ADDR && lq.cnt == 4'h0)
    else $error("start not seen");

  a_stop_detect: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    stopEv && !lq.lockS2 |=> lq.ph == PH_IDLE && !lq.sdaOe)
    else $error("stop not seen");

  a_index_step: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    s_rx_byte_end and lq.ph == PH_RX_DATA |=> lq.idx == $past(idxPlus) && lq.wrValid)
    else $error("index did not advance");

  a_read_index_hold: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    lq.ph == PH_TX || lq.ph == PH_TX_ACK |=> $stable(lq.idx))
    else $error("index moved during read");

  a_data_at_low: assert property (
    @(posedge linkClk) disable iff (!arst_n)
    $changed(lq.sdaOut) && lq.sdaOe |-> !lq.sclS3)
    else $error("data changed while clock high");

  // ---------------------------------------------------------
  // Checks, system domain
  // ---------------------------------------------------------
  a_load_standby: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    sq.mode == MODE_LOAD && !sq.lockS2 |=> sq.mode == MODE_STANDBY)
    else $error("load did not reach standby");

  a_write_lands: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wrHitS && !sq.lockS2 |=> regRead(wrAddrS) == $past(wrDataS))
    else $error("written value lost");
endmodule // rap_register_port
`default_nettype wire

// ### rap_bus_master.sv
// Two-wire bus master model on the serial pins.
// Assumes pull-ups; the bench resolves the data wire.
`timescale 1ns/1ns
`default_nettype none
module rap_bus_master (
  // Pacing clock and resolved data wire
  input  wire logic linkClk,
  input  wire logic sdaWire,
  // Pin drives
  output logic      sclOut,
  output logic      sdaLow
);
  // --------
  // Bit phases
  // --------
  localparam int QTR = 6;  // Quarter bit; keeps clock high >=3 and low >=4 link cycles
  initial begin
    sclOut = 1'b1;  // Clock stands high outside frames
    sdaLow = 1'b0;
  end
  // One quarter bit, stepping off the edge
  task automatic qtr();
    repeat (QTR) @(posedge linkClk);
    #1;
  endtask
  // Start or repeated start, master only
  task automatic start();
    sdaLow = 1'b0;
    qtr();
    sclOut = 1'b1;
    qtr();
    sdaLow = 1'b1;
    qtr();
    sclOut = 1'b0;
  endtask
  // Stop condition
  task automatic stop();
    sdaLow = 1'b1;
    qtr();
    sclOut = 1'b1;
    qtr();
    sdaLow = 1'b0;
    qtr();
  endtask
  // Byte MSB first, data moved only with clock low, then clocked ack slot
  task automatic xfer(input logic [7:0] tx, input logic ackLvl, output logic [7:0] rx, output logic ackSeen);
    logic [8:0] bits;
    bits = {tx, ackLvl};
    for (int i = 8; i >= 0; i--) begin
      qtr();
      sdaLow = ~bits[i];
      qtr();
      sclOut = 1'b1;
      qtr();
      if (i > 0) rx[i-1] = sdaWire;
      else ackSeen = sdaWire;
      qtr();
      sclOut = 1'b0;
    end
  endtask
endmodule // rap_bus_master
`default_nettype wire

// ### tb.sv
// Self-checking bench for the register access port.
// Assumes the bus master model and a pulled-up data wire.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rap_pkg::*;
  // --------
  // Clocks, pins, counters
  // --------
  localparam logic [1:0] ID_CODE  = 2'h1;   // Arbitrary
  localparam logic [7:0] VER_CODE = 8'h5A;  // Arbitrary
  typedef struct packed { logic [7:0] idx; logic [7:0] dat; logic [7:0] exp; } rap_row_type;
  rap_row_type rows [6] = '{'{8'h02, 8'hA1, 8'hA1}, '{8'h07, 8'h5B, 8'h5B}, '{8'h13, 8'hFF, 8'hFF},
                           '{8'h00, 8'h77, {ID_CODE, REV_LOW_RST}}, '{8'h01, 8'h12, VER_CODE},
                           '{8'h14, 8'h66, 8'h00}};
  logic           ref_clk = 1'b0;
  logic           linkClk = 1'b0;
  logic           arst_n = 1'b0;
  logic           supplyLockout = 1'b0;
  logic           sclIn, mstLow, sdaOut, sdaOe;
  logic [143:0]   ctrlRegs;
  logic [143:0]   otpImg;  // Distinct default per register
  logic [1:0]     devMode;
  wire logic      sdaIn;
  int             n_errors = 0;
  int             num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  always #16 linkClk = ~linkClk;
  // Open-drain wire with pull-up
  assign sdaIn = ~((sdaOe & ~sdaOut) | mstLow);
  rap_register_port #(.PART_ID_CODE(ID_CODE), .OTP_VERSION_CODE(VER_CODE)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .supplyLockout(supplyLockout), .otpDefaults(otpImg),
    .ctrlRegs(ctrlRegs), .devMode(devMode));
  rap_bus_master mst (.linkClk(linkClk), .sdaWire(sdaIn), .sclOut(sclIn), .sdaLow(mstLow));
  // --------
  // Checking and bus tasks
  // --------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] regv(input logic [7:0] idx);
    return ctrlRegs[(idx - 8'h02) * 8 +: 8];
  endfunction
  // Bounded wait for standby, then link settling
  task automatic wait_mode();
    int k = 0;
    while (devMode !== 2'h2 && k < 200) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k == 200) begin
      n_errors++;
      print_verdict();
    end else begin
      repeat (4) @(posedge linkClk);
    end
  endtask
  // Address, index and n data bytes, no stop; ackLvl 0 means acked
  task automatic wr(input logic [7:0] adr, idx, d, input int n, input logic ackLvl);
    logic [7:0] rx;
    logic a;
    mst.start();
    mst.xfer(adr, 1'b1, rx, a);
    chk("addr ack", {7'h0, a}, {7'h0, ackLvl});
    mst.xfer(idx, 1'b1, rx, a);
    chk("index ack", {7'h0, a}, {7'h0, ackLvl});
    for (int i = 0; i < n; i++) begin
      mst.xfer(d + 8'(i), 1'b1, rx, a);
      chk("data ack", {7'h0, a}, {7'h0, ackLvl});
    end
  endtask
  // Index write, repeated start, two bytes read: acked then refused
  task automatic rd(input logic [7:0] idx, output logic [7:0] v0, v1);
    logic [7:0] rx;
    logic a;
    wr(8'hC0, idx, 8'h00, 0, 1'b0);
    mst.start();
    mst.xfer(8'hC1, 1'b1, rx, a);
    chk("read addr ack", {7'h0, a}, 8'h00);
    mst.xfer(8'hFF, 1'b0, v0, a);
    mst.xfer(8'hFF, 1'b1, v1, a);
    mst.stop();
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    logic [7:0] v0, v1;
    for (int i = 2; i < 20; i++) otpImg[(i - 2) * 8 +: 8] = 8'hC0 + 8'(i);
    repeat (8) @(posedge ref_clk);
    chk("reset mode", {6'h0, devMode}, 8'h00);
    #1 arst_n = 1'b1;
    wait_mode();
    for (int i = 2; i < 20; i++) chk("load image", regv(8'(i)), 8'hC0 + 8'(i));
    foreach (rows[r]) begin
      wr(8'hC0, rows[r].idx, rows[r].dat, 1, 1'b0);
      mst.stop();
      rd(rows[r].idx, v0, v1);
      chk("read first", v0, rows[r].exp);
      chk("read repeat", v1, rows[r].exp);
      if (rows[r].idx inside {[8'h02:8'h13]}) chk("reg value", regv(rows[r].idx), rows[r].dat);
    end
    // Burst fills consecutive registers
    wr(8'hC0, 8'h05, 8'h90, 3, 1'b0);
    mst.stop();
    for (int i = 0; i < 3; i++) chk("burst", regv(8'h05 + 8'(i)), 8'h90 + 8'(i));
    // Neighbour address is ignored entirely
    wr(8'hC2, 8'h05, 8'h00, 1, 1'b1);
    mst.stop();
    chk("foreign write", regv(8'h05), 8'h90);
    // Lockout: no drive at all, then defaults reloaded
    @(posedge ref_clk);
    #1 supplyLockout = 1'b1;
    wr(8'hC0, 8'h02, 8'h00, 1, 1'b1);
    mst.stop();
    chk("lockout mode", {6'h0, devMode}, 8'h00);
    @(posedge ref_clk);
    #1 supplyLockout = 1'b0;
    wait_mode();
    chk("reload", regv(8'h05), 8'hC5);
    // Mid-run reset wipes the map, then the load runs again
    @(posedge ref_clk);
    #1 arst_n = 1'b0;
    @(posedge ref_clk);
    #1;
    chk("reset map", regv(8'h05), 8'h00);
    chk("reset mode again", {6'h0, devMode}, 8'h00);
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    wait_mode();
    chk("reset reload", regv(8'h07), 8'hC7);
    rd(8'h07, v0, v1);
    chk("read after reset", v0, 8'hC7);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
